// [hdl/usbeps_defines.svh]
// constants for the endpoint packet-size and fifo access block
// assumes inclusion by the endpoint module only
`ifndef USBEPS_DEFINES_SVH
`define USBEPS_DEFINES_SVH
`define USBEPS_BE_LOW_ONLY   2'h1
`define USBEPS_BE_BOTH       2'h3
`define USBEPS_BE_NONE       2'h0
`define USBEPS_ISO_MAX_BYTES 11'h3FF
`define USBEPS_ISO_RAM_BYTES 12'h800
`define USBEPS_FRAME_US      1000
`define USBEPS_CLK_KHZ       10000
`define USBEPS_FRAME_CYCLES  ((`USBEPS_FRAME_US * `USBEPS_CLK_KHZ) / 1000)
`define USBEPS_SIZE_RESET    11'h040
`endif

// [hdl/usbeps_endpoint.sv]
// one endpoint's packet assembly: size limit, final-byte enables, close and frame pacing
// assumes a writer on either the shared bus port or the direct port, synchronous to clk
`include "usbeps_defines.svh"
`timescale 1ns/1ps
`default_nettype none
// Function
// - shared-port receive accepts odd or even size
// - shared-port transmit accepts odd or even size
// - direct-port receive accepts odd or even size
// - per-endpoint path and buffering selection
// - iso payload capped at 1023 bytes
// - one iso transaction per 1 ms frame
// - fifo native even counts, odd via enable
// - size taken from packet-size register field
module usbeps_endpoint #(
	parameter int SIZE_BITS  = 11,
	parameter int FRAME_CYCLES = `USBEPS_FRAME_CYCLES
) (
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	input  wire usbeps_pkg::usbeps_cfg_type cfg,
	input  wire logic [SIZE_BITS-1:0]   endpoint_packet_size_register,
	input  wire usbeps_pkg::usbeps_wr_type shared_wr,
	input  wire logic [1:0]             shared_port_byte_enable,
	input  wire usbeps_pkg::usbeps_wr_type direct_wr,
	input  wire logic [1:0]             direct_port_write_byte_enable,
	input  wire usbeps_pkg::usbeps_cmd_type controller_command_register,
	input  wire logic                   packet_sent,
	output logic [15:0]                 fifo_data,
	output logic                        fifo_data_valid,
	output logic                        fifo_low_only,
	output logic [SIZE_BITS-1:0]        byte_count,
	output logic                        packet_ready,
	output logic                        buffer_bank,
	output logic                        size_error,
	output logic                        overrun_error,
	output logic                        command_error,
	output logic                        frame_tick
);
	import usbeps_pkg::*;
	initial begin
		// the size field must hold 1024 for the odd 1023-byte direct case
		if (SIZE_BITS < 11)
			$error("usbeps_endpoint: SIZE_BITS below 11 cannot hold the largest size");
		// the byte counter compare keeps one spare bit above the field
		if (SIZE_BITS > 16)
			$error("usbeps_endpoint: SIZE_BITS above 16 not supported");
		// the frame counter needs a distinct last value
		if (FRAME_CYCLES < 2)
			$error("usbeps_endpoint: FRAME_CYCLES below 2 not supported");
	end
	// frame length is counted in clk cycles; another clock rate needs FRAME_CYCLES changed
	localparam int FCW = $clog2(FRAME_CYCLES);
	usbeps_state_type state;
	usbeps_state_type next_state;
	logic [FCW-1:0] frame_cnt;
	logic           iso_sent;

	// command decode shared by the close, clear and invalidate paths
	function automatic logic cmd_is(input usbeps_cmd_type c, input usbeps_cmd_type k);
		cmd_is = (c == k);
	endfunction

	// path selection per endpoint
	wire usbeps_wr_type wr_sel = cfg.direct_path ? direct_wr : shared_wr;
	wire [1:0] be_sel = cfg.direct_path ? direct_port_write_byte_enable
		: shared_port_byte_enable;
	wire low_only = (be_sel == `USBEPS_BE_LOW_ONLY);
	// enable 00 moves no bytes: the word is taken but counts as nothing
	wire [1:0] add_bytes = low_only ? 2'h1 : ((be_sel == `USBEPS_BE_NONE) ? 2'h0 : 2'h2);

	// byte lanes of the stored word: the high lane is blanked on a single-byte
	// store so a word read back never carries stale data from the writer
	wire [1:0]  lane_en;
	wire [15:0] lane_data;
	generate
		for (genvar i = 0; i < 2; i++) begin : g_lane
			if (i == 0) begin : g_low
				assign lane_en[i] = 1'b1;
			end else begin : g_high
				assign lane_en[i] = ~low_only;
			end
			assign lane_data[8*i +: 8] = lane_en[i] ? wr_sel.data[8*i +: 8] : 8'h00;
		end
	endgenerate

	wire [SIZE_BITS-1:0] max_packet_bytes = endpoint_packet_size_register;
	// odd sizes only refused on direct-port transmit; receive and shared accept both
	wire odd_refused = cfg.is_transmit & cfg.direct_path
		& max_packet_bytes[0];
	// an oversize iso setting blocks every write rather than truncating silently
	wire iso_oversize = cfg.is_iso
		& (max_packet_bytes > SIZE_BITS'(`USBEPS_ISO_MAX_BYTES));

	// one spare bit keeps a write past the limit visible instead of wrapping
	wire [SIZE_BITS:0] sum = {1'b0, byte_count} + {{(SIZE_BITS-1){1'b0}}, add_bytes};
	wire write_ok = wr_sel.valid & (state != USBEPS_READY) & ~odd_refused & ~iso_oversize;
	wire overrun = write_ok & (sum > {1'b0, max_packet_bytes});
	wire take = write_ok & ~overrun;
	wire [SIZE_BITS-1:0] next_count = sum[SIZE_BITS-1:0];
	// full packet completes itself; odd full size reached by a low-only last write
	wire full_now = take & (next_count == max_packet_bytes);
	wire close_cmd = cmd_is(controller_command_register, USBEPS_CMD_CLOSE);
	wire clear_cmd = cmd_is(controller_command_register, USBEPS_CMD_CLEAR)
		| cmd_is(controller_command_register, USBEPS_CMD_INVALIDATE);

	// during iso filling only clear and invalidate are legal; on the shared
	// port the close command is how an iso packet ends, so it stays legal there
	wire bad_cmd = cfg.is_iso & (state == USBEPS_FILL) & close_cmd
		& cfg.direct_path;
	wire close_ok = close_cmd & (state == USBEPS_FILL) & ~bad_cmd;

	// iso: at most one packet handed over per frame; a second one waits
	// for the next frame to start
	wire frame_end = (frame_cnt == FCW'(FRAME_CYCLES - 1));
	wire send_ok = packet_sent & (state == USBEPS_READY) & ~(cfg.is_iso & iso_sent);

	// a packet is ready from the full or close edge until the link takes it
	assign packet_ready = (state == USBEPS_READY);

	// state flow: idle until the first accepted write, fill while bytes arrive,
	// ready once the size is reached or a close lands; writes in ready are dropped
	// because the buffer belongs to the link until it reports the packet sent
	always_comb begin
		next_state = state;
		case (state)
			USBEPS_IDLE: begin
				if (full_now) begin
					next_state = USBEPS_READY;
				end else if (take) begin
					next_state = USBEPS_FILL;
				end
			end
			USBEPS_FILL: begin
				if (full_now || close_ok) begin
					next_state = USBEPS_READY;
				end
			end
			USBEPS_READY: begin
				if (send_ok) begin
					next_state = USBEPS_IDLE;
				end
			end
			default: begin
				next_state = USBEPS_IDLE;
			end
		endcase
		// clear and invalidate abandon the packet from any state
		if (clear_cmd) begin
			next_state = USBEPS_IDLE;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state <= USBEPS_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// the frame counter runs free; only reset realigns it
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			frame_cnt <= '0;
			iso_sent <= 1'b0;
		end else begin
			frame_cnt <= frame_end ? '0 : frame_cnt + 1'b1;
			iso_sent <= frame_end ? 1'b0 : (iso_sent | send_ok);
		end
	end

	// clear and hand-over both empty the buffer; no write is taken while ready
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			byte_count <= '0;
		end else if (clear_cmd || send_ok) begin
			byte_count <= '0;
		end else if (take) begin
			byte_count <= next_count;
		end
	end

	// dual mode swaps banks on each handed-over packet
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			buffer_bank <= 1'b0;
		end else if (clear_cmd) begin
			buffer_bank <= 1'b0;
		end else if (send_ok && cfg.dual_buffer) begin
			buffer_bank <= ~buffer_bank;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			fifo_data <= 16'h0000;
			fifo_data_valid <= 1'b0;
			fifo_low_only <= 1'b0;
		end else begin
			fifo_data <= take ? lane_data : fifo_data;
			fifo_data_valid <= take & (add_bytes != 2'h0);
			fifo_low_only <= take & low_only;
		end
	end

	// overrun and command errors are sticky, and a new one in the cycle of a clear still sets the flag; size_error follows the setting
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			size_error <= 1'b0;
			overrun_error <= 1'b0;
			command_error <= 1'b0;
			frame_tick <= 1'b0;
		end else begin
			size_error <= odd_refused | iso_oversize;
			overrun_error <= (overrun_error & ~clear_cmd) | overrun;
			command_error <= (command_error & ~clear_cmd) | bad_cmd;
			frame_tick <= frame_end;
		end
	end
endmodule
`default_nettype wire

// [hdl/usbeps_pkg.sv]
// types shared by the endpoint packet-size block
// assumes nothing beyond the defines header
package usbeps_pkg;
	typedef struct packed {
		logic        valid;
		logic [1:0]  be;
		logic [15:0] data;
	} usbeps_wr_type;
	typedef struct packed {
		logic        direct_path;
		logic        dual_buffer;
		logic        is_transmit;
		logic        is_iso;
	} usbeps_cfg_type;
	typedef enum logic [1:0] {USBEPS_CMD_NONE, USBEPS_CMD_CLOSE, USBEPS_CMD_CLEAR,
		USBEPS_CMD_INVALIDATE} usbeps_cmd_type;
	typedef enum {USBEPS_IDLE, USBEPS_FILL, USBEPS_READY} usbeps_state_type;
endpackage

// [test/tb_usbeps_endpoint.sv]
// bench for the endpoint block: sizes, byte enables, errors
// assumes the writer model and checker compile first
`timescale 1ns/1ps
`default_nettype none
module tb_usbeps_endpoint;
	import usbeps_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, go_s = 1'b0, go_d = 1'b0, ps = 1'b0;
	logic [10:0] n = 11'h000, sz = 11'h000, cnt;
	usbeps_cfg_type cfg = '0;
	usbeps_cmd_type cmd = USBEPS_CMD_NONE;
	usbeps_wr_type sw, dw;
	logic [1:0] sbe, dbe;
	logic bank, serr, oerr, cerr, rdy, ft;
	logic [15:0] fd;
	int err_total = 0, n_compared = 0, cyc = 0, ticks = 0, t0 = 0;
	always #50 clk = ~clk;
	always @(posedge clk) if (ft) ticks <= ticks + 1;
	usbeps_writer u_s (.clk(clk), .go(go_s), .n(n), .wr(sw), .be(sbe));
	usbeps_writer u_d (.clk(clk), .go(go_d), .n(n), .wr(dw), .be(dbe));
	usbeps_endpoint #(.FRAME_CYCLES(16)) DUT (.clk(clk), .rst_n(rst_n), .cfg(cfg),
		.endpoint_packet_size_register(sz), .shared_wr(sw), .shared_port_byte_enable(sbe),
		.direct_wr(dw), .direct_port_write_byte_enable(dbe), .controller_command_register(cmd),
		.packet_sent(ps), .fifo_data(fd), .fifo_data_valid(), .fifo_low_only(), .byte_count(cnt),
		.packet_ready(rdy), .buffer_bank(bank), .size_error(serr), .overrun_error(oerr),
		.command_error(cerr), .frame_tick(ft));
	task automatic chk(input logic [10:0] got, input logic [10:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_w(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic pulse_sent();
		@(posedge clk) ps <= 1'b1;
		@(posedge clk) ps <= 1'b0;
	endtask
	task automatic rs(input usbeps_cfg_type c, input logic [10:0] s);
		@(posedge clk) rst_n <= 1'b0;
		cfg <= c;
		sz <= s;
		@(posedge clk) rst_n <= 1'b1;
	endtask
	task automatic send(input logic [10:0] b);
		@(posedge clk) n <= b;
		go_s <= !cfg.direct_path;
		go_d <= cfg.direct_path;
		@(posedge clk) go_s <= 1'b0;
		go_d <= 1'b0;
		repeat (b[10:1] + 11'h003) @(posedge clk);
	endtask
	task automatic cm(input usbeps_cmd_type k);
		@(posedge clk) cmd <= k;
		@(posedge clk) cmd <= USBEPS_CMD_NONE;
		@(posedge clk);
	endtask
	task automatic t_shared();
		rs(4'h6, 11'h005);
		send(11'h005);
		chk(cnt, 11'h005);
		chk(11'(rdy), 11'h001);
		chk_w(fd, 16'h00FE);
		send(11'h002);
		chk(cnt, 11'h005);
		@(posedge clk) ps <= 1'b1;
		@(posedge clk) ps <= 1'b0;
		@(posedge clk) chk(11'(bank), 11'h001);
		chk(11'(rdy), 11'h000);
		rs(4'h0, 11'h007);
		send(11'h007);
		chk(cnt, 11'h007);
		$display("t_shared done");
	endtask
	task automatic t_direct();
		rs(4'hA, 11'h400);
		send(11'h3FF);
		chk(cnt, 11'h3FF);
		rs(4'hA, 11'h005);
		send(11'h000);
		chk(11'(serr), 11'h001);
		rs(4'h8, 11'h005);
		send(11'h005);
		chk(cnt, 11'h005);
		$display("t_direct done");
	endtask
	task automatic t_errors();
		rs(4'h2, 11'h005);
		send(11'h007);
		chk(11'(oerr), 11'h001);
		cm(USBEPS_CMD_CLEAR);
		chk(11'(oerr), 11'h000);
		rs(4'h3, 11'h400);
		send(11'h000);
		chk(11'(serr), 11'h001);
		rs(4'hF, 11'h008);
		send(11'h002);
		cm(USBEPS_CMD_CLOSE);
		chk(11'(cerr), 11'h001);
		cm(USBEPS_CMD_INVALIDATE);
		chk(11'(cerr), 11'h000);
		$display("t_errors done");
	endtask
	task automatic t_iso();
		rs(4'h3, 11'h008);
		send(11'h002);
		cm(USBEPS_CMD_CLOSE);
		chk(11'(cerr), 11'h000);
		chk(11'(rdy), 11'h001);
		rs(4'h3, 11'h002);
		send(11'h002);
		t0 = ticks;
		pulse_sent();
		send(11'h002);
		pulse_sent();
		@(posedge clk) chk(cnt, 11'h002);
		pulse_sent();
		@(posedge clk) chk(cnt, 11'h000);
		chk(11'(ticks - t0), 11'h001);
		$display("t_iso done");
	endtask
	task automatic wrap_up();
		$display("compared %0d mismatched %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_total++;
			wrap_up();
		end
	end
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		t_shared();
		t_direct();
		t_errors();
		t_iso();
		wrap_up();
	end
endmodule
`default_nettype wire

// [test/usbeps_endpoint_asserts.sv]
// checker of endpoint port relations
// assumes binding onto usbeps_endpoint at 11-bit sizes
`timescale 1ns/1ps
`default_nettype none
module usbeps_endpoint_asserts (
	input wire logic                       clk,
	input wire logic                       rst_n,
	input wire usbeps_pkg::usbeps_cfg_type cfg,
	input wire logic [10:0]                endpoint_packet_size_register,
	input wire usbeps_pkg::usbeps_wr_type  shared_wr,
	input wire usbeps_pkg::usbeps_wr_type  direct_wr,
	input wire usbeps_pkg::usbeps_cmd_type controller_command_register,
	input wire logic                       packet_sent,
	input wire logic                       fifo_data_valid,
	input wire logic                       fifo_low_only,
	input wire logic [10:0]                byte_count,
	input wire logic                       size_error,
	input wire logic                       overrun_error
);
	import usbeps_pkg::*;
	wire [10:0] sz = endpoint_packet_size_register;
	wire full = byte_count == sz && sz != 11'h000;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_count_step: assert property (fifo_data_valid |->
		byte_count == $past(byte_count) + (fifo_low_only ? 11'h001 : 11'h002)) else $error("step");
	a_count_cap: assert property (byte_count <= sz) else $error("cap");
	a_full_drain: assert property (full && packet_sent && !cfg.is_iso |=> byte_count == 11'h000) else $error("drain");
	a_odd_direct: assert property (cfg.direct_path && cfg.is_transmit && sz[0] |-> ##[0:1] size_error)
		else $error("odd direct");
	a_iso_cap: assert property (cfg.is_iso && sz > 11'h3FF |-> ##[0:1] size_error) else $error("iso");
	a_shared_ok: assert property ((!cfg.direct_path && !cfg.is_iso)[*2] |-> !size_error)
		else $error("shared size");
	a_clear_err: assert property (controller_command_register == USBEPS_CMD_CLEAR
		&& !shared_wr.valid && !direct_wr.valid |=> !overrun_error)
		else $error("clear");
	a_over_held: assert property (overrun_error && controller_command_register == USBEPS_CMD_NONE
		|=> overrun_error) else $error("sticky");
	c_low: cover property (fifo_low_only);
	c_over: cover property ($rose(overrun_error));
	c_full: cover property (full && packet_sent);
endmodule
bind usbeps_endpoint usbeps_endpoint_asserts u_chk (.*);
`default_nettype wire

// [test/usbeps_writer.sv]
// far-side writer model: streams n bytes as 16-bit words
// assumes go is a one-cycle pulse with n steady
`timescale 1ns/1ps
`default_nettype none
module usbeps_writer (
	input  wire logic                 clk,
	input  wire logic                 go,
	input  wire logic [10:0]          n,
	output usbeps_pkg::usbeps_wr_type wr,
	output logic [1:0]                be
);
	logic [10:0] left = 11'h000;
	always @(posedge clk)
		left <= go ? n : left - ((left > 11'h001) ? 11'h002 : left);
	// lone last byte; a full packet is never closed
	assign be = (left == 11'h000) ? 2'h0 : ((left == 11'h001) ? 2'h1 : 2'h3);
	// valid drops when idle so a stale word cannot pass
	assign wr = '{left != 11'h000, be, {left[7:0], ~left[7:0]}};
endmodule
`default_nettype wire
